// *** rtl/dwm_msg_sender.sv ***
// Sender of data-port write messages built from staged registers
//
// Notes on behaviour
// - Eight-slot type picks low or high depth half
// - Never send a register of ignored data
// - Pass destination depth unchanged from payload
// - Header registers first, payload from position two
// - Refuse type and presence combinations not listed
// - Order: stencil, colour, source, destination depth
// - Type 000: eight colours, two per depth
// - Types 010/011: two sources, one per depth
// - Type 001 one register; 100 four colours
// - Streamed target only buffer or empty, untiled; not checked here, left to software
// - Streamed base and pitch dword aligned; not checked here, left to software
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
module dwm_msg_sender (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [11:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData,
  output logic msgValid,
  input wire logic msgReady,
  output logic [255:0] msgData,
  output logic [3:0] msgPos,
  output logic msgLast,
  output logic [1:0] msgKind,
  output logic [2:0] msgType,
  output logic msgSrcDepth,
  output logic msgStenAa,
  output logic msgDstDepth,
  output logic [3:0] msgExecMask,
  output logic [7:0] msgBindIndex,
  output logic msgIncIndex,
  output logic msgIncPrims,
  output logic msgIncStorage,
  output logic msgEndOfThread
);

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_SEND
  } dwm_state_t;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dwm_state_t state_ff;
  dwm_state_t nxt_state;
  logic [31:0] ctrl_ff;
  logic [3:0] step_ff;
  logic [3:0] nxt_step;
  logic [255:0] data_ff;
  logic [3:0] pos_ff;
  logic last_ff;
  logic done_ff;
  logic illegal_ff;
  logic badSvb_ff;
  logic [31:0] rdData_ff;
  logic incIdx_ff;
  logic incPrims_ff;
  logic incStore_ff;
  logic eot_ff;

  // ----------------------------------------------------------------
  // Decoded fields and helpers
  // ----------------------------------------------------------------
  logic [2:0] ctlType;
  logic [1:0] ctlKind;
  logic [7:0] ctlBti;
  logic isRt;
  logic isSvb;
  logic busy;
  logic stageHit;
  logic ctrlWr;
  logic goWr;
  logic statusWr;
  logic startOk;
  logic rtIllegal;
  logic svbBad;
  logic [3:0] stepSel;
  logic [3:0] planSlot;
  logic planLast;
  logic planLegal;
  logic [3:0] slotSel;
  logic lastSel;
  logic [255:0] stageReg;
  logic [31:0] stageWord;
  logic [31:0] svbIndex;
  logic advance;
  logic wrIsSvb;

  assign ctlType = ctrl_ff[dwm_pkg::CTL_TYPE_LSB +: 3];
  assign ctlKind = ctrl_ff[dwm_pkg::CTL_KIND_LSB +: 2];
  assign ctlBti = ctrl_ff[dwm_pkg::CTL_BTI_LSB +: 8];
  assign isRt = (ctlKind == dwm_pkg::KIND_RT);
  assign isSvb = (ctlKind == dwm_pkg::KIND_SVB);
  assign busy = (state_ff == ST_SEND);

  // Software port decode
  assign stageHit = regAddr[dwm_pkg::STAGE_SEL_BIT];
  assign ctrlWr = regWrite && !stageHit && (regAddr == dwm_pkg::OFF_CTRL);
  assign goWr = regWrite && !stageHit && (regAddr == dwm_pkg::OFF_GO)
                && regWrData[0];
  assign statusWr = regWrite && !stageHit && (regAddr == dwm_pkg::OFF_STATUS);

  // Kind carried by the control word now on the bus
  assign wrIsSvb = (regWrData[dwm_pkg::CTL_KIND_LSB +: 2]
                    == dwm_pkg::KIND_SVB);

  // ----------------------------------------------------------------
  // Staging store and message plan
  // ----------------------------------------------------------------
  dwm_stage_ram u_stage (
    .clk_sys(clk_sys),
    .srst(srst),
    .wrEn(regWrite && stageHit && !busy),
    .wrSlot(regAddr[8:5]),
    .wrDword(regAddr[4:2]),
    .wrData(regWrData),
    .rdSlot(slotSel),
    .rdReg(stageReg),
    .swSlot(regAddr[8:5]),
    .swDword(regAddr[4:2]),
    .swData(stageWord)
  );

  dwm_rt_plan u_plan (
    .msgType(ctlType),
    .srcDepth(ctrl_ff[dwm_pkg::CTL_SRCZ]),
    .stenAa(ctrl_ff[dwm_pkg::CTL_STEN]),
    .dstDepth(ctrl_ff[dwm_pkg::CTL_DSTZ]),
    .hiHalf(ctrl_ff[dwm_pkg::CTL_HIHALF]),
    .step(stepSel),
    .slot(planSlot),
    .last(planLast),
    .legal(planLegal)
  );

  // Step to fetch: first register when idle, the next one while sending
  assign stepSel = busy ? (step_ff + 4'h1) : 4'h0;

  // Streamed and loop-filter messages are one header register
  assign slotSel = isRt ? planSlot : dwm_pkg::SLOT_HDR0;
  assign lastSel = isRt ? planLast : 1'b1;

  // Destination index sits in dword five of the first register
  assign svbIndex = stageReg[dwm_pkg::SVB_IDX_DW*32 +: 32];

  // ----------------------------------------------------------------
  // Start checks
  // ----------------------------------------------------------------
  assign rtIllegal = isRt && !planLegal;
  assign svbBad = isSvb && ((ctlBti == dwm_pkg::BTI_STATELESS)
                  || (svbIndex[31:dwm_pkg::SVB_IDX_BITS] != 5'h00));
  assign startOk = goWr && !busy && !rtIllegal && !svbBad
                   && (ctlKind != 2'h3);
  assign advance = busy && msgReady;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------

  // Next state and step; the step only moves on an accepted register
  always_comb begin
    nxt_state = state_ff;
    nxt_step = step_ff;
    case (state_ff)
      ST_IDLE: begin
        if (startOk) begin
          nxt_state = ST_SEND;
          nxt_step = 4'h0;
        end
      end
      ST_SEND: begin
        if (msgReady) begin
          if (last_ff) begin
            nxt_state = ST_IDLE;
          end else begin
            nxt_step = step_ff + 4'h1;
          end
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // State and step registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_ff <= ST_IDLE;
      step_ff <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      step_ff <= nxt_step;
    end
  end

  // Outgoing register, loaded at start and after each accepted one but the last
  // Registers go out bit for bit as staged: no format change, and
  // destination depth leaves exactly as software wrote it
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      data_ff <= '0;
      pos_ff <= 4'h0;
      last_ff <= 1'b0;
    end else if (startOk || (advance && !last_ff)) begin
      data_ff <= stageReg;
      pos_ff <= stepSel;
      last_ff <= lastSel;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------

  // Control is frozen while a message is in flight
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl_ff <= dwm_pkg::CTL_RESET;
    end else if (ctrlWr && !busy) begin
      ctrl_ff <= regWrData;
    end
  end

  // Side flags follow the control word; the kind gate is applied here
  // so that the bump and end-of-thread outputs leave straight from
  // flops and cannot glitch while the control word settles
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      incIdx_ff <= 1'b0;
      incPrims_ff <= 1'b0;
      incStore_ff <= 1'b0;
      eot_ff <= 1'b0;
    end else if (ctrlWr && !busy) begin
      incIdx_ff <= wrIsSvb && regWrData[dwm_pkg::CTL_INC_IDX];
      incPrims_ff <= wrIsSvb && regWrData[dwm_pkg::CTL_INC_PRIMS];
      incStore_ff <= wrIsSvb && regWrData[dwm_pkg::CTL_INC_STORE];
      eot_ff <= !wrIsSvb && regWrData[dwm_pkg::CTL_EOT];
    end
  end

  // Sticky status; a new event wins over a write-one clear
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      done_ff <= 1'b0;
      illegal_ff <= 1'b0;
      badSvb_ff <= 1'b0;
    end else begin
      if (advance && last_ff) begin
        done_ff <= 1'b1;
      end else if (statusWr && regWrData[dwm_pkg::STS_DONE]) begin
        done_ff <= 1'b0;
      end
      if (goWr && !busy && rtIllegal) begin
        illegal_ff <= 1'b1;
      end else if (statusWr && regWrData[dwm_pkg::STS_ILLEGAL]) begin
        illegal_ff <= 1'b0;
      end
      if (goWr && !busy && svbBad) begin
        badSvb_ff <= 1'b1;
      end else if (statusWr && regWrData[dwm_pkg::STS_BADSVB]) begin
        badSvb_ff <= 1'b0;
      end
    end
  end

  // Read data stands in the cycle after the read strobe only
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdData_ff <= 32'h0000_0000;
    end else if (regRead) begin
      if (stageHit) begin
        rdData_ff <= stageWord;
      end else begin
        case (regAddr)
          dwm_pkg::OFF_CTRL: begin
            rdData_ff <= ctrl_ff;
          end
          dwm_pkg::OFF_STATUS: begin
            rdData_ff <= {28'h000_0000, badSvb_ff, illegal_ff, done_ff, busy};
          end
          dwm_pkg::OFF_STEP: begin
            rdData_ff <= {28'h000_0000, step_ff};
          end
          default: begin
            rdData_ff <= 32'h0000_0000;
          end
        endcase
      end
    end else begin
      rdData_ff <= 32'h0000_0000;
    end
  end

  // Read port output
  assign regRdData = rdData_ff;

  // ----------------------------------------------------------------
  // Message link outputs
  // ----------------------------------------------------------------

  // Link fields straight from their flops
  assign msgValid = busy;
  assign msgData = data_ff;
  assign msgPos = pos_ff;
  assign msgLast = last_ff;
  assign msgKind = ctlKind;
  assign msgType = ctlType;
  assign msgSrcDepth = ctrl_ff[dwm_pkg::CTL_SRCZ];
  assign msgStenAa = ctrl_ff[dwm_pkg::CTL_STEN];
  assign msgDstDepth = ctrl_ff[dwm_pkg::CTL_DSTZ];
  assign msgExecMask = ctrl_ff[dwm_pkg::CTL_MASK_LSB +: 4];
  // The index picks the target surface; software keeps only a linear or
  // empty, untiled, dword aligned surface behind it for streamed writes
  assign msgBindIndex = ctlBti;

  // Counter bumps only ride on streamed writes
  assign msgIncIndex = incIdx_ff;
  assign msgIncPrims = incPrims_ff;
  assign msgIncStorage = incStore_ff;

  // End of thread is suppressed on streamed writes
  assign msgEndOfThread = eot_ff;

endmodule : dwm_msg_sender

// *** shared/dwm_pkg.sv ***
// Constants shared by the data-port message sender and its helpers
package dwm_pkg;

  // ----------------------------------------------------------------
  // Message shape
  // ----------------------------------------------------------------
  localparam int unsigned REG_W = 256;
  localparam int unsigned DW_PER_REG = 8;
  localparam int unsigned SLOT_CNT = 16;
  localparam int unsigned STEP_W = 4;
  localparam int unsigned SLOT_W = 4;

  // Message type codes of a render target write
  localparam logic [2:0] TYPE_SS16 = 3'h0;
  localparam logic [2:0] TYPE_REPL = 3'h1;
  localparam logic [2:0] TYPE_DUAL_LO = 3'h2;
  localparam logic [2:0] TYPE_DUAL_HI = 3'h3;
  localparam logic [2:0] TYPE_SS8 = 3'h4;

  // Message kinds
  localparam logic [1:0] KIND_RT = 2'h0;
  localparam logic [1:0] KIND_SVB = 2'h1;
  localparam logic [1:0] KIND_LF = 2'h2;

  // Fixed staging slots for each part of a message
  localparam logic [3:0] SLOT_HDR0 = 4'h0;
  localparam logic [3:0] SLOT_STEN = 4'h2;
  localparam logic [3:0] SLOT_COL0 = 4'h3;
  localparam logic [3:0] SLOT_SRCZ = 4'hb;
  localparam logic [3:0] SLOT_DSTZ = 4'hd;

  // Colour register counts per type, and the header register count
  localparam logic [4:0] COL_CNT_16 = 5'h08;
  localparam logic [4:0] COL_CNT_REPL = 5'h01;
  localparam logic [4:0] COL_CNT_8 = 5'h04;
  localparam logic [4:0] HDR_CNT = 5'h02;

  // ----------------------------------------------------------------
  // Software port map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_GO = 12'h004;
  localparam logic [11:0] OFF_STATUS = 12'h008;
  localparam logic [11:0] OFF_STEP = 12'h00c;
  localparam int unsigned STAGE_SEL_BIT = 10;

  // Control register fields
  localparam int unsigned CTL_TYPE_LSB = 0;
  localparam int unsigned CTL_SRCZ = 3;
  localparam int unsigned CTL_STEN = 4;
  localparam int unsigned CTL_DSTZ = 5;
  localparam int unsigned CTL_HIHALF = 6;
  localparam int unsigned CTL_KIND_LSB = 8;
  localparam int unsigned CTL_INC_IDX = 10;
  localparam int unsigned CTL_INC_PRIMS = 11;
  localparam int unsigned CTL_INC_STORE = 12;
  localparam int unsigned CTL_EOT = 13;
  localparam int unsigned CTL_MASK_LSB = 16;
  localparam int unsigned CTL_BTI_LSB = 24;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;

  // Status register fields
  localparam int unsigned STS_BUSY = 0;
  localparam int unsigned STS_DONE = 1;
  localparam int unsigned STS_ILLEGAL = 2;
  localparam int unsigned STS_BADSVB = 3;

  // Streamed write header layout
  localparam int unsigned SVB_IDX_DW = 5;
  localparam int unsigned SVB_IDX_BITS = 27;
  localparam logic [7:0] BTI_STATELESS = 8'hff;

endpackage : dwm_pkg

// *** rtl/dwm_stage_ram.sv ***
// Staging store of message registers, written dword by dword
module dwm_stage_ram (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic wrEn,
  input wire logic [3:0] wrSlot,
  input wire logic [2:0] wrDword,
  input wire logic [31:0] wrData,
  input wire logic [3:0] rdSlot,
  output logic [255:0] rdReg,
  input wire logic [3:0] swSlot,
  input wire logic [2:0] swDword,
  output logic [31:0] swData
);

  logic [31:0] mem [dwm_pkg::SLOT_CNT*dwm_pkg::DW_PER_REG];

  // Cleared on reset so nothing unknown ever leaves the block
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int i = 0; i < dwm_pkg::SLOT_CNT*dwm_pkg::DW_PER_REG; i++) begin
        mem[i] <= 32'h0000_0000;
      end
    end else if (wrEn) begin
      mem[{wrSlot, wrDword}] <= wrData;
    end
  end

  // Whole register read, dword 0 in the low bits
  always_comb begin
    for (int d = 0; d < dwm_pkg::DW_PER_REG; d++) begin
      rdReg[d*32 +: 32] = mem[{rdSlot, d[2:0]}];
    end
  end

  assign swData = mem[{swSlot, swDword}];

endmodule : dwm_stage_ram

// *** rtl/dwm_rt_plan.sv ***
// Slot order and legality of render target write messages
module dwm_rt_plan (
  input wire logic [2:0] msgType,
  input wire logic srcDepth,
  input wire logic stenAa,
  input wire logic dstDepth,
  input wire logic hiHalf,
  input wire logic [3:0] step,
  output logic [3:0] slot,
  output logic last,
  output logic legal
);

  logic [4:0] colCnt;
  logic [4:0] depCnt;
  logic [4:0] stenEnd;
  logic [4:0] colEnd;
  logic [4:0] szEnd;
  logic [4:0] total;
  logic [4:0] st5;
  logic [4:0] off;
  logic half;

  // Register counts and section boundaries for the chosen type
  always_comb begin
    colCnt = dwm_pkg::COL_CNT_16;
    depCnt = 5'h01;
    half = 1'b0;
    case (msgType)
      dwm_pkg::TYPE_SS16: begin
        depCnt = 5'h02;
      end
      dwm_pkg::TYPE_REPL: begin
        colCnt = dwm_pkg::COL_CNT_REPL;
      end
      dwm_pkg::TYPE_DUAL_HI: begin
        half = 1'b1;
      end
      dwm_pkg::TYPE_SS8: begin
        colCnt = dwm_pkg::COL_CNT_8;
        half = hiHalf;
      end
      default: begin
        half = 1'b0;
      end
    endcase
    st5 = {1'b0, step};
    stenEnd = dwm_pkg::HDR_CNT + {4'h0, stenAa};
    colEnd = stenEnd + colCnt;
    szEnd = colEnd + (srcDepth ? depCnt : 5'h00);
    total = szEnd + (dstDepth ? depCnt : 5'h00);
  end

  // Header, stencil, colour, source depth, destination depth
  always_comb begin
    off = 5'h00;
    if (st5 < dwm_pkg::HDR_CNT) begin
      slot = step;
    end else if (st5 < stenEnd) begin
      slot = dwm_pkg::SLOT_STEN;
    end else if (st5 < colEnd) begin
      off = st5 - stenEnd;
      slot = dwm_pkg::SLOT_COL0 + off[3:0];
    end else if (st5 < szEnd) begin
      off = (depCnt == 5'h02) ? (st5 - colEnd) : {4'h0, half};
      slot = dwm_pkg::SLOT_SRCZ + off[3:0];
    end else begin
      off = (depCnt == 5'h02) ? (st5 - szEnd) : {4'h0, half};
      slot = dwm_pkg::SLOT_DSTZ + off[3:0];
    end
    last = (st5 == total - 5'h01);
  end

  // Only the listed type and presence combinations go out
  always_comb begin
    legal = (msgType <= dwm_pkg::TYPE_SS8);
    if (dstDepth && !srcDepth) begin
      legal = 1'b0;
    end
    if (stenAa && !srcDepth) begin
      legal = 1'b0;
    end
    if (msgType == dwm_pkg::TYPE_REPL && (srcDepth || stenAa || dstDepth)) begin
      legal = 1'b0;
    end
    if ((msgType == dwm_pkg::TYPE_DUAL_LO || msgType == dwm_pkg::TYPE_DUAL_HI)
        && stenAa && dstDepth) begin
      legal = 1'b0;
    end
  end

endmodule : dwm_rt_plan

// *** verification/dwm_msg_sender_sva.sv ***
// Checker of the message link of the data-port message sender
module dwm_msg_sender_sva (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic msgValid,
  input wire logic msgReady,
  input wire logic [255:0] msgData,
  input wire logic [3:0] msgPos,
  input wire logic msgLast,
  input wire logic [1:0] msgKind,
  input wire logic [2:0] msgType,
  input wire logic msgSrcDepth,
  input wire logic msgStenAa,
  input wire logic msgDstDepth,
  input wire logic [7:0] msgBindIndex,
  input wire logic msgIncIndex,
  input wire logic msgEndOfThread
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // Link properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  first_pos_a: assert property ($rose(msgValid) |-> msgPos == 4'h0)
    else $error("message did not open at position zero");
  hold_reg_a: assert property (msgValid && !msgReady |=> msgValid &&
    $stable(msgData) && $stable(msgPos))
    else $error("register changed before it was taken");
  pos_step_a: assert property (msgValid && msgReady && !msgLast |=>
    msgValid && msgPos == $past(msgPos) + 4'h1)
    else $error("register position did not advance by one");
  last_drop_a: assert property (msgValid && msgReady && msgLast |=>
    !msgValid)
    else $error("register sent after the last one");
  single_reg_a: assert property (msgValid &&
    msgKind != dwm_pkg::KIND_RT |-> msgLast && msgPos == 4'h0)
    else $error("streamed or filter message not one register");
  svb_index_a: assert property (msgValid &&
    msgKind == dwm_pkg::KIND_SVB |-> msgData[191:187] == 5'h00 &&
    msgBindIndex != 8'hff)
    else $error("streamed write with bad index or binding");
  svb_eot_a: assert property (msgKind == dwm_pkg::KIND_SVB |->
    !msgEndOfThread)
    else $error("streamed write carries end of thread");
  inc_gate_a: assert property (msgIncIndex |->
    msgKind == dwm_pkg::KIND_SVB)
    else $error("index increment outside a streamed write");
  combo_legal_a: assert property (msgValid &&
    msgKind == dwm_pkg::KIND_RT |-> !(msgDstDepth && !msgSrcDepth) &&
    msgType <= dwm_pkg::TYPE_SS8)
    else $error("illegal render target combination sent");
  repl_len_a: assert property (msgValid && msgLast &&
    msgKind == dwm_pkg::KIND_RT && msgType == dwm_pkg::TYPE_REPL |->
    msgPos == 4'h2)
    else $error("replicated message has wrong length");
  ss16_len_a: assert property (msgValid && msgLast &&
    msgKind == dwm_pkg::KIND_RT && msgType == dwm_pkg::TYPE_SS16 |->
    msgPos == 4'h9 + {3'h0, msgStenAa} + {2'h0, msgSrcDepth, 1'b0} +
    {2'h0, msgDstDepth, 1'b0})
    else $error("sixteen-slot message has wrong length");
endmodule : dwm_msg_sender_sva

// *** verification/dwm_dev_model.sv ***
// Model of the surface-memory side that takes message registers
module dwm_dev_model (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic slow,
  input wire logic msgValid,
  input wire logic [255:0] msgData,
  output logic msgReady
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [255:0] rxQ[$];

  // Ready every cycle when prompt, every other cycle when slow
  always @(posedge clk_sys) begin
    if (srst) begin
      msgReady <= 1'b0;
    end else begin
      msgReady <= slow ? !msgReady : 1'b1;
    end
  end
  // Take each register whole, dword zero lowest, in arrival order
  always @(posedge clk_sys) begin
    if (!srst && msgValid && msgReady) begin
      rxQ.push_back(msgData);
    end
  end
endmodule : dwm_dev_model

// *** verification/tb_top.sv ***
// Self-checking bench of the data-port message sender
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, srst, regWrite, regRead, msgReady, slow;
  logic [11:0] regAddr;
  logic [31:0] regWrData, regRdData, rdVal;
  logic [31:0] seed = 32'h0000_1363;
  logic msgValid, msgLast, msgSrcDepth, msgStenAa, msgDstDepth;
  logic msgIncIndex, msgIncPrims, msgIncStorage, msgEndOfThread;
  logic [255:0] msgData;
  logic [255:0] stage [16];
  logic [3:0] msgPos, msgExecMask;
  logic [1:0] msgKind;
  logic [2:0] msgType;
  logic [7:0] msgBindIndex;
  logic [11:0] rstAddr [4] = '{12'h000, 12'h008, 12'h00c, 12'h400};
  logic [31:0] ctls [12] = '{32'h0000_0038, 32'h0000_0001, 32'h0000_002a,
    32'h0000_001b, 32'h0000_006c, 32'h0000_003c, 32'h0000_0000,
    32'h0000_0020, 32'h0000_0009, 32'h0000_003a, 32'h0000_0005,
    32'h0000_0014};
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int expQ[$];

  dwm_msg_sender dut (.clk_sys, .srst, .regAddr, .regWrData, .regWrite,
    .regRead, .regRdData, .msgValid, .msgReady, .msgData, .msgPos,
    .msgLast, .msgKind, .msgType, .msgSrcDepth, .msgStenAa, .msgDstDepth,
    .msgExecMask, .msgBindIndex, .msgIncIndex, .msgIncPrims,
    .msgIncStorage, .msgEndOfThread);
  dwm_dev_model dev (.clk_sys, .srst, .slow, .msgValid, .msgData,
    .msgReady);

  // ------------------------------------------------------------
  // Clock, timeout and helpers
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Cut a hang short
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 8000) begin
      num_errors++;
      complete_run();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task complete_run();
    $display("comparisons %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  task chk(input logic [255:0] seen, input logic [255:0] exp, string m);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t ns: %s", $time, m);
    end
  endtask : chk

  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask : wr

  task rd(input logic [11:0] a);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1;
    rdVal = regRdData;
  endtask : rd

  // Reference order of staged slots for one control word
  task plan(input logic [31:0] c);
    int t, s, a, d, h, n;
    t = c[2:0];
    s = c[3];
    a = c[4];
    d = c[5];
    h = c[6];
    expQ.delete();
    if (c[9:8] == 2'h1 && (c[31:24] == 8'hff || stage[0][191:187] != 0))
      return;
    if (c[9:8] != 2'h0) begin
      expQ.push_back(0);
      return;
    end
    if (t > 4 || (d && !s) || (a && !s) || (t == 1 && (s || a || d)) ||
        (t > 1 && t < 4 && a && d)) return;
    n = (t == 1) ? 1 : (t == 4) ? 4 : 8;
    expQ = {0, 1};
    if (a) expQ.push_back(2);
    for (int i = 0; i < n; i++) expQ.push_back(3 + i);
    if (s) expQ.push_back((t == 3 || (t == 4 && h)) ? 12 : 11);
    if (s && t == 0) expQ.push_back(12);
    if (d) expQ.push_back((t == 3 || (t == 4 && h)) ? 14 : 13);
    if (d && t == 0) expQ.push_back(14);
  endtask : plan

  // One message: program, start, wait, then compare all results
  task send(input logic [31:0] c);
    logic [3:0] st;
    logic [23:0] ob, sd;
    logic v;
    plan(c);
    st = expQ.size() ? 4'h2 : (c[9:8] == 2'h1) ? 4'h8 : 4'h4;
    v = (c[9:8] == 2'h1);
    sd = {c[31:24], c[9:8], c[5:3], c[2:0], c[19:16], v && c[10],
      v && c[11], v && c[12], !v && c[13]};
    dev.rxQ.delete();
    wr(12'h000, c);
    wr(12'h004, 32'h0000_0001);
    for (int i = 0; i < 300 && (msgValid || i == 0); i++) begin
      @(posedge clk_sys);
      #1;
    end
    ob = {msgBindIndex, msgKind, msgDstDepth, msgStenAa, msgSrcDepth,
      msgType, msgExecMask, msgIncIndex, msgIncPrims, msgIncStorage,
      msgEndOfThread};
    chk(256'(ob), 256'(sd), "side outputs");
    rd(12'h008);
    chk(256'(rdVal[3:0]), 256'(st), "status");
    chk(256'(dev.rxQ.size()), 256'(expQ.size()), "length");
    foreach (expQ[i]) begin
      if (i < dev.rxQ.size())
        chk(dev.rxQ[i], stage[expQ[i]], "register");
    end
    wr(12'h008, 32'h0000_000e);
    $display("case %h ended", c);
  endtask : send

  task set_index(input logic [31:0] v);
    wr(12'h414, v);
    stage[0][191:160] = v;
  endtask : set_index

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    srst = 1'b1;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 12'h000;
    regWrData = 32'h0000_0000;
    slow = 1'b0;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    foreach (rstAddr[i]) begin
      rd(rstAddr[i]);
      chk(256'(rdVal), 256'h0, "reset value");
    end
    $display("reset test ended");
    for (int k = 0; k < 128; k++) begin
      rdVal = rnd();
      wr(12'h400 + 12'(k * 4), rdVal);
      stage[k / 8][(k % 8) * 32 +: 32] = rdVal;
    end
    foreach (ctls[j]) begin
      slow <= j[0];
      send(ctls[j]);
    end
    set_index(32'h07ff_ffff);
    send(32'h050a_3d00);
    slow <= 1'b1;
    send(32'hff0a_3d00);
    send(32'h0303_2200);
    set_index(32'h0800_0000);
    send(32'h050a_3d00);
    complete_run();
  end
endmodule : tb_top

bind dwm_msg_sender dwm_msg_sender_sva chk (.clk_sys, .srst, .msgValid,
  .msgReady, .msgData, .msgPos, .msgLast, .msgKind, .msgType,
  .msgSrcDepth, .msgStenAa, .msgDstDepth, .msgBindIndex, .msgIncIndex,
  .msgEndOfThread);
